// File: core/ram_block.sv
// embedded ram block: dual-port ram, shift register, rom and fifo
`include "ram_consts.svh"
module ram_block (
    input  wire logic clk,
    input  wire logic reset,
    ram_link_if.device lnk,
    output logic      cfg_bad
);
    logic [17:0]     mem [0:`RAM_WORDS-1];
    ram_pkg::width_t wa;
    ram_pkg::width_t rw_b;
    logic            is_ram;
    logic            is_rom;
    logic            is_shift;
    logic            is_fifo;
    logic            a_in;
    logic            a_out;
    logic            b_in;
    logic            b_out;
    logic [11:0]     ea_a;
    logic [11:0]     ea_b;
    logic [7:0]      idx_a;
    logic [7:0]      idx_b;
    logic [17:0]     mask_a;
    logic [17:0]     mask_b;
    logic [17:0]     rd_a;
    logic [17:0]     rd_b;
    logic            wr_a;
    logic            wr_b;
    logic            push;
    logic            pop;
    logic [17:0]     ft_a;
    logic [17:0]     ft_b;
    logic [17:0]     oq_a;
    logic [17:0]     oq_b;
    logic [12:0]     sp;
    logic [12:0]     shift_len;
    logic [35:0]     next_taps;
    logic [11:0]     wp;
    logic [11:0]     rp;
    logic [12:0]     cnt;

    function automatic logic [4:0] offset(ram_pkg::width_t w,
                                          logic [3:0] lane);
        return 5'(lane * ram_pkg::bits_of(w));
    endfunction

    function automatic logic [17:0] fit(logic [17:0] d,
                                        ram_pkg::width_t w);
        return d & ((18'h1 << ram_pkg::bits_of(w)) - 18'h1);
    endfunction

    function automatic logic [17:0] lane_mask(ram_pkg::width_t w,
                                              logic [11:0] a);
        return fit(18'h3ffff, w) << offset(w, ram_pkg::lane_of(a, w));
    endfunction

    function automatic logic [17:0] get(logic [17:0] word,
                                        ram_pkg::width_t w,
                                        logic [11:0] a);
        return fit(word >> offset(w, ram_pkg::lane_of(a, w)), w);
    endfunction

    // only 1..16 and 9/18 shapes exist; 32/36 cannot be coded
    assign wa       = lnk.width_a;
    assign is_ram   = lnk.mode == ram_pkg::mode_ram;
    assign is_rom   = lnk.mode == ram_pkg::mode_rom;
    assign is_shift = lnk.mode == ram_pkg::mode_shift;
    assign is_fifo  = lnk.mode == ram_pkg::mode_fifo;
    assign rw_b     = is_fifo ? wa : lnk.width_b;

    // illegal widths, groups or clocking stop the block
    assign cfg_bad = (wa == ram_pkg::w_bad)
                  || (lnk.width_b == ram_pkg::w_bad)
                  || (lnk.clock_mode == ram_pkg::clk_rd_wr)
                  || (is_ram && (ram_pkg::is_nine(wa)
                      != ram_pkg::is_nine(lnk.width_b)));

    // per-port enables stand in for the port clocks
    always_comb
    begin
        a_in  = lnk.en_in_a;
        a_out = lnk.en_in_a;
        b_in  = lnk.en_in_b;
        b_out = lnk.en_in_b;
        unique case (lnk.clock_mode)
            ram_pkg::clk_indep: ;
            ram_pkg::clk_in_out:
            begin
                a_out = lnk.en_out_a;
                b_out = lnk.en_out_b;
            end
            ram_pkg::clk_rd_wr: ;
            ram_pkg::clk_single:
            begin
                b_in  = lnk.en_in_a;
                b_out = lnk.en_in_a;
            end
        endcase
    end

    assign ea_a   = is_shift ? sp[11:0] : (is_fifo ? wp : lnk.addr_a);
    assign ea_b   = is_fifo ? rp : lnk.addr_b;
    assign idx_a  = ram_pkg::word_of(ea_a, wa);
    assign idx_b  = ram_pkg::word_of(ea_b, rw_b);
    assign mask_a = lane_mask(wa, ea_a);
    assign mask_b = lane_mask(rw_b, ea_b);
    assign rd_a   = get(mem[idx_a], wa, ea_a);
    assign rd_b   = get(mem[idx_b], rw_b, ea_b);

    // both ports may write in the same cycle
    assign wr_a = !cfg_bad && a_in && lnk.we_a
               && (is_ram || is_shift || (is_fifo && !lnk.fifo_full));
    assign wr_b = !cfg_bad && b_in && lnk.we_b && is_ram;
    assign push = is_fifo && wr_a;
    // a pop beside a push into an empty fifo is dropped
    assign pop  = is_fifo && !cfg_bad && b_in && lnk.fifo_pop
               && !lnk.fifo_empty;

    // storage: no reset, contents stand as preloaded
    always_ff @(posedge clk)
    begin
        if (wr_a && wr_b && idx_a == idx_b)
            mem[idx_a] <= (mem[idx_a] & ~(mask_a | mask_b))
                        | ((fit(lnk.din_a, wa) << offset(wa,
                            ram_pkg::lane_of(ea_a, wa))) & mask_a)
                        | ((fit(lnk.din_b, rw_b) << offset(rw_b,
                            ram_pkg::lane_of(ea_b, rw_b))) & mask_b);
        else
        begin
            if (wr_a)
                mem[idx_a] <= (mem[idx_a] & ~mask_a)
                            | ((fit(lnk.din_a, wa) << offset(wa,
                                ram_pkg::lane_of(ea_a, wa))) & mask_a);
            if (wr_b)
                mem[idx_b] <= (mem[idx_b] & ~mask_b)
                            | ((fit(lnk.din_b, rw_b) << offset(rw_b,
                                ram_pkg::lane_of(ea_b, rw_b))) & mask_b);
        end
    end

    // port a address stage; reset is a clocked power-up clear
    always_ff @(posedge clk)
    begin
        if (reset)
            ft_a <= 18'h0;
        else if (a_in && !cfg_bad && (is_ram || is_rom))
            ft_a <= wr_a ? fit(lnk.din_a, wa) : rd_a;
    end

    // port b address stage
    always_ff @(posedge clk)
    begin
        if (reset)
            ft_b <= 18'h0;
        else if (b_in && !cfg_bad && (is_ram || is_rom))
        begin
            if (wr_b)
                ft_b <= fit(lnk.din_b, rw_b);
            else if (wr_a && idx_a == idx_b && !lnk.rdw_old)
                ft_b <= fit(18'h3ffff, rw_b);
            else
                ft_b <= rd_b;
        end
    end

    // optional output registers on the output enables
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            oq_a <= 18'h0;
            oq_b <= 18'h0;
        end
        else
        begin
            if (a_out)
                oq_a <= ft_a;
            if (b_out)
                oq_b <= ft_b;
        end
    end

    assign lnk.q_a = lnk.outreg_a ? oq_a : ft_a;
    assign lnk.q_b = is_fifo ? (lnk.fifo_empty ? 18'h0 : rd_b)
                   : (lnk.outreg_b ? oq_b : ft_b);

    // shift register: taps read from old contents, then write
    assign shift_len = 13'(lnk.tap_len * lnk.tap_cnt);

    always_comb
    begin
        logic [12:0] back;
        logic [12:0] ta;
        logic [17:0] v;
        int          w;
        back      = 13'h0;
        ta        = 13'h0;
        v         = 18'h0;
        w         = int'(ram_pkg::bits_of(wa));
        next_taps = 36'h0;
        for (int k = 1; k <= `RAM_TAP_BITS; k++)
        begin
            if (k <= int'(lnk.tap_cnt))
            begin
                back = 13'(k * int'(lnk.tap_len));
                ta   = (sp >= back) ? 13'(sp - back)
                                    : 13'(sp + shift_len - back);
                v    = get(mem[ram_pkg::word_of(ta[11:0], wa)], wa,
                           ta[11:0]);
                for (int b = 0; b < `RAM_WORD_BITS; b++)
                    if (b < w && (k - 1) * w + b < `RAM_TAP_BITS)
                        next_taps[(k - 1) * w + b] = v[b];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            lnk.taps <= 36'h0;
        else if (is_shift && wr_a)
            lnk.taps <= next_taps;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            sp <= 13'h0;
        else if (!is_shift)
            sp <= 13'h0;
        else if (wr_a)
            sp <= (sp + 13'h1 >= shift_len) ? 13'h0 : sp + 13'h1;
    end

    // fifo pointers and fill count
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wp  <= 12'h0;
            rp  <= 12'h0;
            cnt <= 13'h0;
        end
        else if (!is_fifo)
        begin
            wp  <= 12'h0;
            rp  <= 12'h0;
            cnt <= 13'h0;
        end
        else
        begin
            if (push)
                wp <= (13'(wp) + 13'h1 == ram_pkg::depth_of(wa))
                      ? 12'h0 : wp + 12'h1;
            if (pop)
                rp <= (13'(rp) + 13'h1 == ram_pkg::depth_of(wa))
                      ? 12'h0 : rp + 12'h1;
            if (push && !pop)
                cnt <= cnt + 13'h1;
            else if (pop && !push)
                cnt <= cnt - 13'h1;
        end
    end

    assign lnk.fifo_empty = cnt == 13'h0;
    assign lnk.fifo_full  = cnt == ram_pkg::depth_of(wa);
endmodule

// File: core/ram_consts.svh
// offsets, field positions and limits of the embedded ram block
`ifndef RAM_CONSTS_SVH
`define RAM_CONSTS_SVH
`define RAM_WORDS        256
`define RAM_WORD_BITS    18
`define RAM_ADDR_BITS    12
`define RAM_TAP_BITS     36
`define SHIFT_MAX_BITS   4608
`define SHIFT_MAX_WIDTH  36
`define REG_CFG          4'h0
`define REG_TAP          4'h1
`define REG_DIV          4'h2
`define REG_CMD_A        4'h3
`define REG_CMD_B        4'h4
`define REG_STAT         4'h5
`define REG_Q_B          4'h6
`define REG_TAPS_LO      4'h7
`define REG_TAPS_HI      4'h8
`define CFG_MODE_LSB     0
`define CFG_CLOCK_LSB    2
`define CFG_WA_LSB       4
`define CFG_WB_LSB       7
`define CFG_OUTREG_A     10
`define CFG_OUTREG_B     11
`define CFG_RDW_OLD      12
`define TAP_CNT_LSB      16
`define DIV_B_LSB        8
`define CMD_DATA_LSB     12
`define CMD_WE           30
`define CMD_POP          31
`define CFG_RESET        32'h0000_0000
`endif

// File: core/ram_pkg.sv
// types and width decoding shared by both ends
package ram_pkg;
    typedef enum logic [1:0] {
        mode_ram   = 2'b00,
        mode_shift = 2'b01,
        mode_rom   = 2'b10,
        mode_fifo  = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        clk_indep  = 2'b00,
        clk_in_out = 2'b01,
        clk_rd_wr  = 2'b10,
        clk_single = 2'b11
    } clock_t;
    typedef enum logic [2:0] {
        w1 = 3'b000, w2 = 3'b001, w4 = 3'b010, w8 = 3'b011,
        w16 = 3'b100, w9 = 3'b101, w18 = 3'b110, w_bad = 3'b111
    } width_t;

    function automatic logic [4:0] bits_of(width_t w);
        case (w)
            w1:      return 5'h01;
            w2:      return 5'h02;
            w4:      return 5'h04;
            w8:      return 5'h08;
            w16:     return 5'h10;
            w9:      return 5'h09;
            w18:     return 5'h12;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [2:0] lane_log(width_t w);
        case (w)
            w1:      return 3'h4;
            w2:      return 3'h3;
            w4:      return 3'h2;
            w8:      return 3'h1;
            w9:      return 3'h1;
            default: return 3'h0;
        endcase
    endfunction

    function automatic logic [7:0] word_of(logic [11:0] a, width_t w);
        return 8'(a >> lane_log(w));
    endfunction

    function automatic logic [3:0] lane_of(logic [11:0] a, width_t w);
        return 4'(a & ((12'h1 << lane_log(w)) - 12'h1));
    endfunction

    function automatic logic [12:0] depth_of(width_t w);
        return 13'(13'h100 << lane_log(w));
    endfunction

    function automatic logic is_nine(width_t w);
        return (w == w9) || (w == w18);
    endfunction
endpackage

// File: core/ram_link_if.sv
// link between the user logic and the embedded ram block
interface ram_link_if;
    ram_pkg::mode_t        mode;
    ram_pkg::clock_t       clock_mode;
    ram_pkg::width_t       width_a;
    ram_pkg::width_t       width_b;
    logic                  outreg_a;
    logic                  outreg_b;
    logic                  rdw_old;
    logic [12:0]           tap_len;
    logic [5:0]            tap_cnt;
    logic                  en_in_a;
    logic                  en_out_a;
    logic                  en_in_b;
    logic                  en_out_b;
    logic [11:0]           addr_a;
    logic [11:0]           addr_b;
    logic [17:0]           din_a;
    logic [17:0]           din_b;
    logic                  we_a;
    logic                  we_b;
    logic                  fifo_pop;
    logic [17:0]           q_a;
    logic [17:0]           q_b;
    logic [35:0]           taps;
    logic                  fifo_empty;
    logic                  fifo_full;

    modport device (
        input  mode, clock_mode, width_a, width_b, outreg_a, outreg_b,
        input  rdw_old, tap_len, tap_cnt, en_in_a, en_out_a, en_in_b,
        input  en_out_b, addr_a, addr_b, din_a, din_b, we_a, we_b,
        input  fifo_pop,
        output q_a, q_b, taps, fifo_empty, fifo_full
    );
    modport user (
        output mode, clock_mode, width_a, width_b, outreg_a, outreg_b,
        output rdw_old, tap_len, tap_cnt, en_in_a, en_out_a, en_in_b,
        output en_out_b, addr_a, addr_b, din_a, din_b, we_a, we_b,
        output fifo_pop,
        input  q_a, q_b, taps, fifo_empty, fifo_full
    );
endinterface

// File: core/ram_user.sv
// user logic that drives both ports of the ram block
`include "ram_consts.svh"
module ram_user (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    ram_link_if.user         lnk
);
    logic [31:0] cfg;
    logic [31:0] tap;
    logic [15:0] div;
    logic [31:0] cmd_a;
    logic [31:0] cmd_b;
    logic        pend_a;
    logic        pend_b;
    logic [7:0]  cnt_a;
    logic [7:0]  cnt_b;
    logic        pa;
    logic        pb;
    logic        pulse_b;
    logic        fire_a;
    logic        fire_b;
    logic        clash;
    logic        size_err;
    logic [31:0] shift_bits;

    assign lnk.mode       = ram_pkg::mode_t'(cfg[`CFG_MODE_LSB +: 2]);
    assign lnk.clock_mode = ram_pkg::clock_t'(cfg[`CFG_CLOCK_LSB +: 2]);
    assign lnk.width_a    = ram_pkg::width_t'(cfg[`CFG_WA_LSB +: 3]);
    assign lnk.width_b    = ram_pkg::width_t'(cfg[`CFG_WB_LSB +: 3]);
    assign lnk.outreg_a   = cfg[`CFG_OUTREG_A];
    assign lnk.outreg_b   = cfg[`CFG_OUTREG_B];
    assign lnk.rdw_old    = cfg[`CFG_RDW_OLD];
    assign lnk.tap_len    = tap[12:0];
    assign lnk.tap_cnt    = tap[`TAP_CNT_LSB +: 6];
    assign lnk.addr_a     = cmd_a[11:0];
    assign lnk.addr_b     = cmd_b[11:0];
    assign lnk.din_a      = cmd_a[`CMD_DATA_LSB +: 18];
    assign lnk.din_b      = cmd_b[`CMD_DATA_LSB +: 18];

    // shift shape must fit the block
    assign shift_bits = 32'(lnk.tap_len) * 32'(lnk.tap_cnt)
                      * 32'(ram_pkg::bits_of(lnk.width_a));
    assign size_err = lnk.mode == ram_pkg::mode_shift
        && (shift_bits > `SHIFT_MAX_BITS
            || 32'(lnk.tap_cnt) * 32'(ram_pkg::bits_of(lnk.width_a))
               > `SHIFT_MAX_WIDTH
            || lnk.tap_cnt == 6'h0 || lnk.tap_len == 13'h0
            || 13'(lnk.tap_len * lnk.tap_cnt)
               > ram_pkg::depth_of(lnk.width_a));

    // port rate dividers give one-cycle enables
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_a <= 8'h0;
            cnt_b <= 8'h0;
            pa    <= 1'b0;
            pb    <= 1'b0;
        end
        else
        begin
            pa    <= cnt_a >= div[7:0];
            cnt_a <= (cnt_a >= div[7:0]) ? 8'h0 : cnt_a + 8'h1;
            pb    <= cnt_b >= div[`DIV_B_LSB +: 8];
            cnt_b <= (cnt_b >= div[`DIV_B_LSB +: 8]) ? 8'h0 : cnt_b + 8'h1;
        end
    end

    assign pulse_b      = (lnk.clock_mode == ram_pkg::clk_single) ? pa : pb;
    assign lnk.en_in_a  = pa;
    assign lnk.en_out_a = pa;
    assign lnk.en_in_b  = pulse_b;
    assign lnk.en_out_b = pulse_b;

    assign fire_a = pend_a && pa && !size_err;
    // same word written by both ports: b waits
    assign clash = fire_a && cmd_a[`CMD_WE] && cmd_b[`CMD_WE]
        && ram_pkg::word_of(lnk.addr_a, lnk.width_a)
           == ram_pkg::word_of(lnk.addr_b, lnk.width_b);
    // no pop beside a push while empty
    assign fire_b = pend_b && pulse_b && !clash
        && !(cmd_b[`CMD_POP] && lnk.fifo_empty
             && fire_a && cmd_a[`CMD_WE]);
    assign lnk.we_a     = fire_a && cmd_a[`CMD_WE];
    assign lnk.we_b     = fire_b && cmd_b[`CMD_WE];
    assign lnk.fifo_pop = fire_b && cmd_b[`CMD_POP];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cfg    <= `CFG_RESET;
            tap    <= 32'h0;
            div    <= 16'h0;
            cmd_a  <= 32'h0;
            cmd_b  <= 32'h0;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
        end
        else
        begin
            if (wr && addr == `REG_CFG)
                cfg <= wdata;
            if (wr && addr == `REG_TAP)
                tap <= wdata;
            if (wr && addr == `REG_DIV)
                div <= wdata[15:0];
            if (wr && addr == `REG_CMD_A)
                cmd_a <= wdata;
            if (wr && addr == `REG_CMD_B)
                cmd_b <= wdata;
            pend_a <= (wr && addr == `REG_CMD_A) || (pend_a && !fire_a);
            pend_b <= (wr && addr == `REG_CMD_B) || (pend_b && !fire_b);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata <= 32'h0;
        else if (rd)
        begin
            case (addr)
                `REG_CFG:     rdata <= cfg;
                `REG_TAP:     rdata <= tap;
                `REG_DIV:     rdata <= {16'h0, div};
                `REG_STAT:    rdata <= {9'h0, size_err, lnk.fifo_full,
                                        lnk.fifo_empty, pend_b, pend_a,
                                        lnk.q_a};
                `REG_Q_B:     rdata <= {14'h0, lnk.q_b};
                `REG_TAPS_LO: rdata <= lnk.taps[31:0];
                `REG_TAPS_HI: rdata <= {28'h0, lnk.taps[35:32]};
                default:      rdata <= 32'h0;
            endcase
        end
    end
endmodule

// File: bench/ram_monitor.sv
// concurrent checks on the link between user logic and ram block
module ram_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input ram_pkg::mode_t   mode,
    input ram_pkg::clock_t  clock_mode,
    input ram_pkg::width_t  width_a,
    input ram_pkg::width_t  width_b,
    input wire logic        outreg_a,
    input wire logic        outreg_b,
    input wire logic        en_in_a,
    input wire logic        en_in_b,
    input wire logic [11:0] addr_a,
    input wire logic [11:0] addr_b,
    input wire logic [17:0] din_a,
    input wire logic [17:0] din_b,
    input wire logic        we_a,
    input wire logic        we_b,
    input wire logic        fifo_pop,
    input wire logic [17:0] q_a,
    input wire logic [17:0] q_b,
    input wire logic [35:0] taps,
    input wire logic        fifo_empty,
    input wire logic        fifo_full
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic ram16;
    logic fifo;
    logic shift;
    assign ram16 = mode == ram_pkg::mode_ram
        && clock_mode == ram_pkg::clk_indep
        && width_a == ram_pkg::w16 && width_b == ram_pkg::w16;
    assign fifo = mode == ram_pkg::mode_fifo;
    assign shift = mode == ram_pkg::mode_shift;
    sequence s_wr_a;
        en_in_a && we_a;
    endsequence
    sequence s_first_push;
        fifo && fifo_empty && width_a == ram_pkg::w16 ##0 s_wr_a;
    endsequence
    chk_flow_a: assert property (ram16 && !outreg_a ##0 s_wr_a
        |=> q_a[15:0] == $past(din_a[15:0])) else $error("port a flow");
    chk_flow_b: assert property (ram16 && !outreg_b && en_in_b && we_b
        |=> q_b[15:0] == $past(din_b[15:0])) else $error("port b flow");
    chk_hold_a: assert property (ram16 && !en_in_a ##1 ram16
        |-> $stable(q_a)) else $error("port a moved without enable");
    chk_hold_b: assert property (ram16 && !en_in_b ##1 ram16
        |-> $stable(q_b)) else $error("port b moved without enable");
    chk_no_clash: assert property (ram16 ##0 s_wr_a
        ##0 (en_in_b && we_b) |-> addr_a != addr_b)
        else $error("write clash");
    chk_empty_head: assert property (fifo && fifo_empty
        |-> q_b == 18'h0) else $error("empty fifo shows data");
    chk_not_both: assert property (fifo
        |-> !(fifo_empty && fifo_full)) else $error("empty and full");
    chk_first_push: assert property (s_first_push ##1 fifo
        |-> !fifo_empty && q_b[15:0] == $past(din_a[15:0]))
        else $error("first push not at head");
    chk_no_rw_empty: assert property (fifo && fifo_empty && en_in_a
        && we_a |-> !(en_in_b && fifo_pop)) else $error("pop with push");
    chk_taps_idle: assert property (shift && !(en_in_a && we_a)
        ##1 shift |-> $stable(taps)) else $error("taps moved");
    chk_zero_start: assert property ($fell(reset)
        |-> q_a == 18'h0 && q_b == 18'h0) else $error("outputs not zero");
endmodule

// File: bench/tb.sv
// self-checking bench for the ram block and its user logic
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        reset;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        cfg_bad;
    logic [31:0] s;
    logic [31:0] cw [6];
    logic        cx [6];
    int          miscompares;
    int          checks;
    ram_link_if lnk();
    ram_block ram_block_inst (.clk(clk), .reset(reset), .lnk(lnk),
        .cfg_bad(cfg_bad));
    ram_user ram_user_inst (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk));
    ram_monitor ram_monitor_inst (.clk(clk), .reset(reset),
        .mode(lnk.mode), .clock_mode(lnk.clock_mode),
        .width_a(lnk.width_a), .width_b(lnk.width_b),
        .outreg_a(lnk.outreg_a), .outreg_b(lnk.outreg_b),
        .en_in_a(lnk.en_in_a), .en_in_b(lnk.en_in_b),
        .addr_a(lnk.addr_a), .addr_b(lnk.addr_b), .din_a(lnk.din_a),
        .din_b(lnk.din_b), .we_a(lnk.we_a), .we_b(lnk.we_b),
        .fifo_pop(lnk.fifo_pop), .q_a(lnk.q_a), .q_b(lnk.q_b),
        .taps(lnk.taps), .fifo_empty(lnk.fifo_empty),
        .fifo_full(lnk.fifo_full));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // poll status until both ports have no pending command
    task automatic settle();
        for (int n = 0; n < 40; n++)
        begin
            rd_reg(4'h5, s);
            if (s[19:18] === 2'b00)
                break;
        end
    endtask
    task automatic op(logic port, logic [31:0] w);
        wr_reg(port ? 4'h4 : 4'h3, w);
        settle();
    endtask
    function automatic logic [31:0] cfg(logic [1:0] m, logic [1:0] c,
        logic [2:0] a, logic [2:0] b);
        return {22'h0, b, a, c, m};
    endfunction
    function automatic logic [31:0] cmd(logic pop, logic we,
        logic [17:0] d, logic [11:0] a);
        return {pop, we, d, a};
    endfunction
    initial
    begin
        #500000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        reset = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1 check(32'(lnk.q_b), 32'h0);
        rd_reg(4'h5, s);
        check(32'(s[17:0]), 32'h0);
        $display("test power-up done");
        wr_reg(4'h0, cfg(ram_pkg::mode_ram, ram_pkg::clk_indep,
            ram_pkg::w16, ram_pkg::w16));
        op(0, cmd(0, 1, 18'h01234, 12'h005));
        check(32'(s[17:0]), 32'h1234);
        op(1, cmd(0, 0, 18'h0, 12'h005));
        rd_reg(4'h6, s);
        check(s, 32'h1234);
        op(1, cmd(0, 1, 18'h0beef, 12'h009));
        rd_reg(4'h6, s);
        check(s, 32'hbeef);
        op(0, cmd(0, 0, 18'h0, 12'h009));
        check(32'(s[17:0]), 32'hbeef);
        // slow port enables so both commands are pending together
        wr_reg(4'h2, 32'h0000_0303);
        wr_reg(4'h3, cmd(0, 1, 18'h00111, 12'h003));
        wr_reg(4'h4, cmd(0, 1, 18'h00222, 12'h003));
        settle();
        wr_reg(4'h2, 32'h0);
        op(0, cmd(0, 0, 18'h0, 12'h003));
        check(32'(s[17:0]), 32'h0222);
        wr_reg(4'h0, cfg(ram_pkg::mode_ram, ram_pkg::clk_indep,
            ram_pkg::w8, ram_pkg::w16));
        op(0, cmd(0, 0, 18'h0, 12'h00a));
        check(32'(s[17:0]), 32'h34);
        op(0, cmd(0, 0, 18'h0, 12'h00b));
        check(32'(s[17:0]), 32'h12);
        $display("test dual-port done");
        // width codes: 4=16, 5=9, 6=18, 1=2, 0=1, 7=none, 3=8
        cw = '{cfg(0, 0, 4, 5), cfg(0, 0, 5, 6), cfg(0, 0, 1, 4),
            cfg(0, 0, 6, 0), cfg(0, 0, 7, 3), cfg(0, 2, 3, 3)};
        cx = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(4'h0, cw[i]);
            @(posedge clk);
            #1 check(32'(cfg_bad), 32'(cx[i]));
        end
        $display("test configuration done");
        wr_reg(4'h0, cfg(ram_pkg::mode_rom, ram_pkg::clk_indep,
            ram_pkg::w16, ram_pkg::w16));
        op(0, cmd(0, 1, 18'h01111, 12'h009));
        check(32'(s[17:0]), 32'hbeef);
        wr_reg(4'h0, cfg(ram_pkg::mode_ram, ram_pkg::clk_single,
            ram_pkg::w16, ram_pkg::w16) | 32'h0000_0800);
        op(1, cmd(0, 0, 18'h0, 12'h005));
        rd_reg(4'h6, s);
        check(s, 32'h1234);
        $display("test rom and output register done");
        wr_reg(4'h0, cfg(ram_pkg::mode_fifo, ram_pkg::clk_indep,
            ram_pkg::w16, ram_pkg::w16));
        rd_reg(4'h5, s);
        check(32'(s[21:20]), 32'h1);
        op(0, cmd(0, 1, 18'h00055, 12'h0));
        op(1, cmd(1, 0, 18'h0, 12'h0));
        check(32'(s[21:20]), 32'h1);
        for (int i = 1; i <= 256; i++)
            op(0, cmd(0, 1, 18'(i), 12'h0));
        check(32'(s[21:20]), 32'h2);
        op(0, cmd(0, 1, 18'h003ff, 12'h0));
        rd_reg(4'h6, s);
        check(s, 32'h1);
        for (int i = 0; i < 255; i++)
            op(1, cmd(1, 0, 18'h0, 12'h0));
        rd_reg(4'h6, s);
        check(s, 32'h100);
        op(1, cmd(1, 0, 18'h0, 12'h0));
        op(1, cmd(1, 0, 18'h0, 12'h0));
        check(32'(s[21:20]), 32'h1);
        rd_reg(4'h6, s);
        check(s, 32'h0);
        $display("test fifo done");
        wr_reg(4'h0, cfg(ram_pkg::mode_shift, ram_pkg::clk_indep,
            ram_pkg::w8, ram_pkg::w8));
        wr_reg(4'h1, 32'h0002_0004);
        for (int i = 0; i < 12; i++)
            op(0, cmd(0, 1, 18'(i + 1), 12'h0));
        check(32'(s[22]), 32'h0);
        rd_reg(4'h7, s);
        check(s, 32'h0000_0408);
        wr_reg(4'h1, 32'h0005_0004);
        rd_reg(4'h5, s);
        check(32'(s[22]), 32'h1);
        wr_reg(4'h1, 32'h0001_0241);
        rd_reg(4'h5, s);
        check(32'(s[22]), 32'h1);
        $display("test shift done");
        end_sim();
    end
endmodule
